//--- clk_reset_ctrl.sv
// Core clock ratio selection, peripheral and bit clock generation, core reset release.
// Assumes clk_i stands for the core clock; ref clock, reset pin and ratio pins are async.
//
// Functional notes
// [RULE1] Core ratio comes from ratio pins sampled while the reset pin is held low.
// [RULE2] Each serial port has its own programmable bit clock divider.
// [RULE3] Peripheral clock is the core clock divided by two.
// [RULE4] Serial port period is peripheral period times its divider setting.
// [RULE5] SPI clock period is peripheral period times the SPI rate register.
// [RULE6] Software may select other core ratios through the power control register.
// [RULE7] Core reset releases 4096 input clocks plus two core clocks after pin rises.
// [RULE8] A missed setup may add one input clock, never beyond 4097.
// [RULE9] Later resets must hold the pin low for at least four input clocks.
// [RULE10] Ratio pins must be stable 20 us before reset deasserts.
// [RULE11] Reset stays asserted until the input clock is stable 10 us.
// [RULE12] Software ratio changes must keep core period at or above 3.0 ns.
// [RULE13] Software must program the multiplier to reach the full core rate.
// [RULE14] Pin ratio is latched at reset release and kept until software overrides.
// [RULE15] Core and all derived clocks stay held until release count completes.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ns
module clk_reset_ctrl #(
    parameter int unsigned REF_CYCLES = clkrst_pkg::REF_RELEASE_CYCLES
) (
    input  wire logic                          clk_i,
    input  wire logic                          reset_n_i,
    input  wire logic                          ref_clock_in_i,
    input  wire logic                          reset_pin_n_i,
    input  wire logic [1:0]                    ratio_select_pins_i,
    input  wire logic [clkrst_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [clkrst_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output logic      [clkrst_pkg::DATA_W-1:0] rdata_o,
    output logic                               core_reset_n_o,
    output logic      [clkrst_pkg::MULT_W-1:0] core_ratio_o,
    output logic                               periph_clk_o,
    output logic      [1:0]                    serial_port_unit_clk_o,
    output logic                               spi_clk_o
);

    // ====================================================================
    // Declarations
    logic [3:0]                       sync1_reg;
    logic [3:0]                       sync2_reg;
    logic                             ref_prev_reg;
    logic                             ref_rise;
    logic                             pin_high;
    logic [1:0]                       pins_s;
    clkrst_pkg::release_state_type    state_reg;
    logic [clkrst_pkg::REF_CNT_W-1:0] ref_cnt_reg;
    logic [1:0]                       core_cnt_reg;
    logic [1:0]                       pins_latched_reg;
    logic [clkrst_pkg::MULT_W-1:0]    mult_reg;
    logic                             sw_sel_reg;
    logic [clkrst_pkg::DIV_W-1:0]     div_reg [3];
    logic                             periph_reg;
    logic                             released;
    logic [clkrst_pkg::DATA_W-1:0]    status_word;

    localparam logic [clkrst_pkg::REF_CNT_W-1:0] REF_LAST = clkrst_pkg::REF_CNT_W'(REF_CYCLES - 1);
    localparam logic [1:0] CORE_LAST = 2'(clkrst_pkg::CORE_EXTRA_CYCLES - 1);

    // ====================================================================
    // Two-stage synchronisers for every pin
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= {ratio_select_pins_i, reset_pin_n_i, ref_clock_in_i};
            sync2_reg <= sync1_reg;
        end
    end

    // Edge history taken from the second stage only
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_prev_reg <= 1'b0;
        end else begin
            ref_prev_reg <= sync2_reg[0];
        end
    end

    assign ref_rise = sync2_reg[0] & ~ref_prev_reg;
    assign pin_high = sync2_reg[1];
    assign pins_s   = sync2_reg[3:2];

    // ====================================================================
    // Reset release sequencer; a low pin always restarts it
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= clkrst_pkg::RS_HOLD;
        end else if (!pin_high) begin
            state_reg <= clkrst_pkg::RS_HOLD;
        end else begin
            case (state_reg)
                clkrst_pkg::RS_HOLD: state_reg <= clkrst_pkg::RS_REF;
                // [RULE7] input clock count
                // [RULE8] sync latency adds at most one input clock
                clkrst_pkg::RS_REF: begin
                    if (ref_rise && ref_cnt_reg == REF_LAST) begin
                        state_reg <= clkrst_pkg::RS_CORE;
                    end
                end
                // [RULE7] two core clocks
                clkrst_pkg::RS_CORE: begin
                    if (core_cnt_reg == CORE_LAST) begin
                        state_reg <= clkrst_pkg::RS_RUN;
                    end
                end
                clkrst_pkg::RS_RUN: state_reg <= clkrst_pkg::RS_RUN;
                default: state_reg <= clkrst_pkg::RS_HOLD;
            endcase
        end
    end

    // Counters of the release sequence
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_cnt_reg  <= '0;
            core_cnt_reg <= 2'h0;
        end else begin
            if (state_reg != clkrst_pkg::RS_REF) begin
                ref_cnt_reg <= '0;
            end else if (ref_rise) begin
                ref_cnt_reg <= ref_cnt_reg + 1'b1;
            end
            if (state_reg != clkrst_pkg::RS_CORE) begin
                core_cnt_reg <= 2'h0;
            end else begin
                core_cnt_reg <= core_cnt_reg + 2'h1;
            end
        end
    end

    assign released = (state_reg == clkrst_pkg::RS_RUN);

    // Core reset from a flop
    // [RULE15] held until release done
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_reset_n_o <= 1'b0;
        end else begin
            core_reset_n_o <= released;
        end
    end

    // ====================================================================
    // Ratio pins are tracked during reset; the value at release is kept
    // [RULE14] latch on release
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pins_latched_reg <= clkrst_pkg::PINS_RST;
        end else if (!pin_high) begin
            pins_latched_reg <= pins_s;
        end
    end

    // Effective multiplier handed to the PLL
    // [RULE1] pin ratio default
    // [RULE6] software override
    // [RULE12] no clamp: software keeps the core period legal
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_ratio_o <= clkrst_pkg::pin_ratio(clkrst_pkg::PINS_RST);
        end else if (sw_sel_reg) begin
            core_ratio_o <= mult_reg;
        end else begin
            core_ratio_o <= clkrst_pkg::pin_ratio(pins_latched_reg);
        end
    end

    // ====================================================================
    // Register writes; a new reset pin cycle drops the software override
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mult_reg   <= clkrst_pkg::MULT_RST;
            sw_sel_reg <= clkrst_pkg::SW_SEL_RST;
        end else if (!pin_high) begin
            sw_sel_reg <= clkrst_pkg::SW_SEL_RST;
        end else if (wr_i && addr_i == clkrst_pkg::POWER_OFS) begin
            mult_reg   <= wdata_i[clkrst_pkg::MULT_LSB +: clkrst_pkg::MULT_W];
            sw_sel_reg <= wdata_i[clkrst_pkg::SW_SEL_BIT];
        end
    end

    // Divider settings
    // [RULE5] SPI rate register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_reg[0] <= clkrst_pkg::DIV_RST;
            div_reg[1] <= clkrst_pkg::DIV_RST;
            div_reg[2] <= clkrst_pkg::DIV_RST;
        end else if (wr_i) begin
            case (addr_i)
                clkrst_pkg::SPORT0_DIV_OFS: div_reg[0] <= wdata_i[clkrst_pkg::DIV_W-1:0];
                clkrst_pkg::SPORT1_DIV_OFS: div_reg[1] <= wdata_i[clkrst_pkg::DIV_W-1:0];
                clkrst_pkg::SPI_RATE_OFS:   div_reg[2] <= wdata_i[clkrst_pkg::DIV_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Read data one cycle after the strobe, unmapped reads as zero
    always_comb begin
        status_word = '0;
        status_word[clkrst_pkg::STAT_RATIO_LSB +: clkrst_pkg::MULT_W] = core_ratio_o;
        status_word[clkrst_pkg::STAT_PINS_LSB +: 2] = pins_latched_reg;
        status_word[clkrst_pkg::STAT_RELEASED] = released;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            case (addr_i)
                clkrst_pkg::POWER_OFS:      rdata_o <= {23'h0, sw_sel_reg, 2'h0, mult_reg};
                clkrst_pkg::SPORT0_DIV_OFS: rdata_o <= {16'h0000, div_reg[0]};
                clkrst_pkg::SPORT1_DIV_OFS: rdata_o <= {16'h0000, div_reg[1]};
                clkrst_pkg::SPI_RATE_OFS:   rdata_o <= {16'h0000, div_reg[2]};
                clkrst_pkg::STATUS_OFS:     rdata_o <= status_word;
                default:                    rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    // ====================================================================
    // Peripheral clock: toggles every core cycle once released
    // [RULE3] divide by two
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            periph_reg <= 1'b0;
        end else if (!released) begin
            periph_reg <= 1'b0;
        end else begin
            periph_reg <= ~periph_reg;
        end
    end

    assign periph_clk_o = periph_reg;

    // ====================================================================
    // Bit clock dividers: two serial ports and SPI
    div_if dif [3] ();

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_div
            // [RULE15] dividers follow release
            assign dif[g].run   = released;
            assign dif[g].ratio = div_reg[g];
            clk_divider u_div (
                .clk_i     (clk_i),
                .reset_n_i (reset_n_i),
                .port      (dif[g])
            );
        end
    endgenerate

    assign serial_port_unit_clk_o[0] = dif[0].div_clk;
    assign serial_port_unit_clk_o[1] = dif[1].div_clk;
    assign spi_clk_o      = dif[2].div_clk;

    // ====================================================================
    // Checks
    sequence core_phase_s;
        (state_reg == clkrst_pkg::RS_CORE) [*2] ##1 (state_reg == clkrst_pkg::RS_RUN);
    endsequence
    chk_core_extra: assert property (@(posedge clk_i) // [RULE7]
        disable iff (!reset_n_i || !pin_high)
        $rose(state_reg == clkrst_pkg::RS_CORE) |-> core_phase_s)
        else $error("core phase not two cycles");
    chk_ref_count: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE8]
        $rose(state_reg == clkrst_pkg::RS_CORE) |-> $past(ref_cnt_reg) == REF_LAST)
        else $error("release count wrong");
    chk_hold_reset: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE15]
        !released |=> !core_reset_n_o && !periph_reg)
        else $error("core left reset early");
    chk_pin_restart: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE9]
        !pin_high |=> state_reg == clkrst_pkg::RS_HOLD)
        else $error("low pin did not restart");
    chk_pin_latch: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE14]
        (pin_high && $past(pin_high) && !$rose(pin_high)) |=> $stable(pins_latched_reg))
        else $error("pin ratio changed after release");
    chk_pin_ratio: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE1]
        !sw_sel_reg ##1 !sw_sel_reg |->
            core_ratio_o == clkrst_pkg::pin_ratio($past(pins_latched_reg)))
        else $error("pin ratio not applied");
    chk_sw_ratio: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE6]
        (wr_i && addr_i == clkrst_pkg::POWER_OFS && wdata_i[clkrst_pkg::SW_SEL_BIT] && pin_high)
            |=> ##1 core_ratio_o == $past(wdata_i[clkrst_pkg::MULT_W-1:0], 2))
        else $error("software ratio not applied");
    chk_periph_half: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE3]
        (released && $past(released)) |-> periph_reg != $past(periph_reg))
        else $error("peripheral clock not half rate");

endmodule

//--- clkrst_pkg.sv
// Constants, register map and state encoding of the clock and reset release block.
// Assumes a single 25 MHz system clock that stands in for the core clock.
package clkrst_pkg;

    // ====================================================================
    // Bus widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned DIV_W  = 16;
    localparam int unsigned MULT_W = 6;

    // ====================================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] POWER_OFS      = 8'h00;
    localparam logic [7:0] SPORT0_DIV_OFS = 8'h04;
    localparam logic [7:0] SPORT1_DIV_OFS = 8'h08;
    localparam logic [7:0] SPI_RATE_OFS   = 8'h0C;
    localparam logic [7:0] STATUS_OFS     = 8'h10;

    // ====================================================================
    // Field positions
    localparam int unsigned MULT_LSB        = 0;
    localparam int unsigned SW_SEL_BIT      = 8;
    localparam int unsigned STAT_RATIO_LSB  = 0;
    localparam int unsigned STAT_PINS_LSB   = 8;
    localparam int unsigned STAT_RELEASED   = 16;

    // ====================================================================
    // Reset values
    localparam logic [MULT_W-1:0] MULT_RST   = 6'h06;
    localparam logic              SW_SEL_RST = 1'b0;
    localparam logic [DIV_W-1:0]  DIV_RST    = 16'h0004;
    localparam logic [1:0]        PINS_RST   = 2'h0;

    // ====================================================================
    // Pin-selected core to input clock ratios (plain defaults)
    localparam logic [MULT_W-1:0] RATIO_SEL0 = 6'h06;
    localparam logic [MULT_W-1:0] RATIO_SEL1 = 6'h20;
    localparam logic [MULT_W-1:0] RATIO_SEL2 = 6'h10;
    localparam logic [MULT_W-1:0] RATIO_SEL3 = 6'h06;

    // ====================================================================
    // Timing counts
    localparam int unsigned REF_RELEASE_CYCLES = 4096;
    localparam int unsigned CORE_EXTRA_CYCLES  = 2;
    localparam int unsigned REF_CNT_W          = 13;

    // ====================================================================
    // Reset release states
    typedef enum logic [3:0] {
        RS_HOLD = 4'b0001,
        RS_REF  = 4'b0010,
        RS_CORE = 4'b0100,
        RS_RUN  = 4'b1000
    } release_state_type;

    // Pin code to multiplier
    function automatic logic [MULT_W-1:0] pin_ratio(input logic [1:0] sel);
        case (sel)
            2'h0:    pin_ratio = RATIO_SEL0;
            2'h1:    pin_ratio = RATIO_SEL1;
            2'h2:    pin_ratio = RATIO_SEL2;
            default: pin_ratio = RATIO_SEL3;
        endcase
    endfunction

endpackage

//--- div_if.sv
// Link between the control block and one bit-clock divider.
// Assumes both ends share the system clock.
`timescale 1ns/1ns
interface div_if;
    logic                           run;
    logic [clkrst_pkg::DIV_W-1:0]   ratio;
    logic                           div_clk;

    modport ctrl (output run, output ratio, input div_clk);
    modport div  (input run, input ratio, output div_clk);
endinterface

//--- clk_divider.sv
// One divided bit clock: period is ratio peripheral periods.
// Assumes run is synchronous to clk_i and ratio is static while running.
`timescale 1ns/1ns
module clk_divider (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    div_if.div        port
);

    logic [clkrst_pkg::DIV_W-1:0] cnt_reg;
    logic [clkrst_pkg::DIV_W-1:0] last;
    logic                         clk_reg;

    // Zero ratio behaves as one so the clock never freezes
    assign last = (port.ratio == 16'h0000) ? 16'h0000 : port.ratio - 16'h0001;
    assign port.div_clk = clk_reg;

    // ====================================================================
    // Half period of ratio core cycles gives ratio peripheral periods
    // [RULE2] per-port divide count
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_reg <= 16'h0000;
            clk_reg <= 1'b0;
        end else if (!port.run) begin
            cnt_reg <= 16'h0000;
            clk_reg <= 1'b0;
        end else if (cnt_reg >= last) begin
            cnt_reg <= 16'h0000;
            clk_reg <= ~clk_reg;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end

    // ====================================================================
    // Checks
    chk_div_toggle: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE4]
        (port.run && $past(port.run) && cnt_reg >= last) |=> (clk_reg != $past(clk_reg)))
        else $error("divider missed its toggle");

    chk_div_stopped: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE15]
        !port.run |=> (!clk_reg && cnt_reg == 16'h0000))
        else $error("divider ran while held");

endmodule

//--- board_source.sv
// Board side model: free running reference oscillator and board reset source.
// Assumes the testbench calls its tasks from procedural code.
`timescale 1ns/1ns
module board_source #(
    parameter int REF_NS  = 100,
    parameter int LOW_REF = 8
) (
    output logic       ref_clock_in_o,
    output logic       reset_pin_n_o,
    output logic [1:0] ratio_select_pins_o
);
    // ====================================================================
    // Oscillator runs free, phase unrelated to the system clock
    initial begin
        ref_clock_in_o = 1'b0;
        #7;
        forever #(REF_NS/2) ref_clock_in_o = ~ref_clock_in_o;
    end

    initial begin
        reset_pin_n_o       = 1'b0;
        ratio_select_pins_o = 2'h0;
    end

    // long low pulse
    // Pins change only at the start of the pulse, so they settle before release
    task automatic hold_reset(input logic [1:0] pins);
        @(negedge ref_clock_in_o);
        reset_pin_n_o       = 1'b0;
        ratio_select_pins_o = pins;
        repeat (LOW_REF) @(negedge ref_clock_in_o);
    endtask

    task automatic release_reset();
        @(negedge ref_clock_in_o);
        reset_pin_n_o = 1'b1;
    endtask
endmodule

//--- testbench.sv
// Self-checking bench for the clock and reset release block.
// Assumes a shortened release count and the board model beside the block.
`timescale 1ns/1ns
module testbench;
    localparam int REF_CYCLES = 4;
    localparam int REF_NS     = 100;
    // Release window in system clocks; covers sync flops and one extra ref cycle
    localparam int REL_LO     = (REF_CYCLES - 1) * REF_NS / 40 + 5;
    localparam int REL_HI     = (REF_CYCLES + 1) * REF_NS / 40 + 10;
    logic                          clk_i;
    logic                          reset_n_i;
    logic                          ref_clock_in;
    logic                          reset_pin_n;
    logic [1:0]                    ratio_pins;
    logic [clkrst_pkg::ADDR_W-1:0] addr_i;
    logic [clkrst_pkg::DATA_W-1:0] wdata_i;
    logic                          wr_i;
    logic                          rd_i;
    logic [clkrst_pkg::DATA_W-1:0] rdata_o;
    logic                          core_reset_n_o;
    logic [clkrst_pkg::MULT_W-1:0] core_ratio_o;
    logic                          periph_clk_o;
    logic [1:0]                    serial_port_unit_clk_o;
    logic                          spi_clk_o;
    logic [3:0]                    clks;
    int                            failures;
    int                            total_checks;

    assign clks = {spi_clk_o, serial_port_unit_clk_o, periph_clk_o};

    clk_reset_ctrl #(.REF_CYCLES(REF_CYCLES)) dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .ref_clock_in_i(ref_clock_in),
        .reset_pin_n_i(reset_pin_n), .ratio_select_pins_i(ratio_pins),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .core_reset_n_o(core_reset_n_o), .core_ratio_o(core_ratio_o),
        .periph_clk_o(periph_clk_o), .serial_port_unit_clk_o(serial_port_unit_clk_o), .spi_clk_o(spi_clk_o)
    );

    board_source #(.REF_NS(REF_NS), .LOW_REF(200)) board (
        .ref_clock_in_o(ref_clock_in), .reset_pin_n_o(reset_pin_n),
        .ratio_select_pins_o(ratio_pins)
    );

    // ====================================================================
    // Clock, closing and compare helpers
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic report_and_stop();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check_value(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_time(input string name, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            failures++;
            $display("unexpected %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask

    // Bus cycles; one idle edge between strobes keeps each driver single
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    // Bounded waits on the block's own outputs
    task automatic wait_release(output int n);
        n = 0;
        while (core_reset_n_o !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask

    task automatic high_time(input int idx, output int n);
        int k;
        k = 0;
        n = 0;
        while (clks[idx] !== 1'b0 && k < 100) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        while (clks[idx] !== 1'b1 && k < 100) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        while (clks[idx] === 1'b1 && k < 100) begin
            @(posedge clk_i);
            #1;
            k++;
            n++;
        end
    endtask

    // ====================================================================
    // Scenarios
    task automatic test_defaults();
        logic [31:0] d;
        read_reg(clkrst_pkg::POWER_OFS, d);
        check_value("power ctrl", 32'h0000_0006, d);
        read_reg(clkrst_pkg::SPORT0_DIV_OFS, d);
        check_value("sport0 div", 32'h0000_0004, d);
        read_reg(clkrst_pkg::SPORT1_DIV_OFS, d);
        check_value("sport1 div", 32'h0000_0004, d);
        read_reg(clkrst_pkg::SPI_RATE_OFS, d);
        check_value("spi rate", 32'h0000_0004, d);
        write_reg(8'h14, 32'hFFFF_FFFF);
        read_reg(8'h14, d);
        check_value("unmapped", 32'h0000_0000, d);
        write_reg(clkrst_pkg::STATUS_OFS, 32'h0000_0000);
        read_reg(clkrst_pkg::STATUS_OFS, d);
        check_value("status", 32'h0001_0006, d);
        @(posedge clk_i);
        #1;
        check_value("rdata idle", 32'h0000_0000, rdata_o);
        $display("test defaults done");
    endtask

    task automatic test_pin_ratios();
        logic [5:0]  tab [4] = '{clkrst_pkg::RATIO_SEL0, clkrst_pkg::RATIO_SEL1,
                                 clkrst_pkg::RATIO_SEL2, clkrst_pkg::RATIO_SEL3};
        logic [31:0] d;
        int          n;
        for (int p = 0; p < 4; p++) begin
            board.hold_reset(2'(p));
            check_value("held clocks", 32'h0000_0000, {28'h0, clks});
            check_value("held core", 32'h0000_0000, {31'h0, core_reset_n_o});
            board.release_reset();
            wait_release(n);
            check_time("release delay", REL_LO, REL_HI, n);
            check_value("pin ratio", {26'h0, tab[p]}, {26'h0, core_ratio_o});
            read_reg(clkrst_pkg::STATUS_OFS, d);
            check_value("status pins", 32'(p), {30'h0, d[9:8]});
        end
        $display("test pin ratios done");
    endtask

    task automatic test_sw_ratio();
        int n;
        write_reg(clkrst_pkg::POWER_OFS, 32'h0000_0120);
        @(posedge clk_i);
        #1;
        check_value("sw ratio", 32'h0000_0020, {26'h0, core_ratio_o});
        write_reg(clkrst_pkg::POWER_OFS, 32'h0000_0110);
        @(posedge clk_i);
        #1;
        check_value("sw ratio 2", 32'h0000_0010, {26'h0, core_ratio_o});
        board.hold_reset(2'h1);
        write_reg(clkrst_pkg::POWER_OFS, 32'h0000_0105);
        board.release_reset();
        wait_release(n);
        check_value("pin ratio back", {26'h0, clkrst_pkg::RATIO_SEL1}, {26'h0, core_ratio_o});
        $display("test software ratio done");
    endtask

    task automatic test_dividers();
        int exp_half [4] = '{1, 3, 5, 7};
        int n;
        board.hold_reset(2'h0);
        write_reg(clkrst_pkg::SPORT0_DIV_OFS, 32'h0000_0003);
        write_reg(clkrst_pkg::SPORT1_DIV_OFS, 32'h0000_0005);
        write_reg(clkrst_pkg::SPI_RATE_OFS, 32'h0000_0007);
        board.release_reset();
        wait_release(n);
        for (int i = 0; i < 4; i++) begin
            high_time(i, n);
            check_time("half period", exp_half[i], exp_half[i], n);
        end
        $display("test dividers done");
    endtask

    // ====================================================================
    // Main sequence and watchdog
    initial begin
        int n;
        failures     = 0;
        total_checks = 0;
        reset_n_i    = 1'b0;
        addr_i       = 8'h00;
        wdata_i      = 32'h0000_0000;
        wr_i         = 1'b0;
        rd_i         = 1'b0;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        board.hold_reset(2'h0);
        board.release_reset();
        wait_release(n);
        test_defaults();
        test_pin_ratios();
        test_sw_ratio();
        test_dividers();
        report_and_stop();
    end

    // Whole run needs roughly 140 us of seven 20 us reset pulses; the limit leaves ample margin
    initial begin
        #400000;
        failures++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule
